// ---- verilog/cxp_pkg.sv ----
package cxp_pkg;
  // Register byte addresses
  localparam logic [7:0] CXP_EQ_LO = 8'h10;
  localparam logic [7:0] CXP_EQ_HI = 8'h11;
  localparam logic [7:0] CXP_POL_LO = 8'h12;
  localparam logic [7:0] CXP_POL_HI = 8'h13;
  localparam logic [7:0] CXP_UPD = 8'h80;
  localparam logic [7:0] CXP_SEL = 8'h81;
  localparam logic [7:0] CXP_BCAST = 8'h82;
  localparam logic [7:0] CXP_MAP0 = 8'h90;
  localparam logic [7:0] CXP_MAP1 = 8'h98;
  localparam logic [7:0] CXP_STAT = 8'hb0;
  // Reset values; nibble n of a map is output n
  localparam logic [63:0] CXP_MAP0_RST = 64'h0123456789abcdef;
  localparam logic [63:0] CXP_MAP1_RST = 64'hfedcba9876543210;
  localparam logic [15:0] CXP_EQ_RST = 16'hffff;
  localparam logic [15:0] CXP_POL_RST = 16'h0000;
  // Upper five bits of the serial slave address
  localparam logic [4:0] CXP_I2C_BASE = 5'h12;
  // Serial frame bit counts: command, address, data byte ends
  localparam logic [4:0] CXP_SPI_CMD_END = 5'd7;
  localparam logic [4:0] CXP_SPI_ADR_END = 5'd15;
  localparam logic [4:0] CXP_SPI_WR_END = 5'd23;
  localparam logic [4:0] CXP_SPI_RD_BEG = 5'd24;
  localparam logic [4:0] CXP_SPI_LAST = 5'd31;

  // One access passed from the serial clock to the system clock
  typedef struct packed {
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } cxp_req_type;

  // Pins that cross into the system clock
  typedef struct packed {
    logic mode;
    logic amsb;
    logic alsb;
    logic scl;
    logic sda;
    logic upd;
    logic [15:0] lane;
  } cxp_pins_type;

  localparam cxp_pins_type CXP_PINS_RST = '{1'b0, 1'b0, 1'b0, 1'b1,
                                            1'b1, 1'b1, 16'h0000};

  typedef enum {
    CXP_I_IDLE,
    CXP_I_ADDR,
    CXP_I_REG,
    CXP_I_WDATA,
    CXP_I_RDATA
  } cxp_i2c_state_type;
endpackage

// ---- verilog/cxp_crosspoint_config_maps.sv ----
// What this block does
// - any output takes any input, nonblocking
// - four-bit field per output names input
// - two ranks: pending map, active map
// - two eight-byte maps, host read/write
// - map 0 default, bytes 0x90 to 0x97
// - map 0 resets to input 15 minus n
// - map 1 resets to input n
// - select register at 0x81 picks map
// - select bit 0 picks map, resets zero
// - broadcast at 0x82 fills selected map
// - writing 0x01 at 0x80 copies map
// - update register is write only
// - strobe pin falling edge starts update
// - status 0xb0 to 0xb7 shows active rank
// - per-input boost bit, resets to one
// - per-input polarity bit, 0x12 and 0x13
// - mode pin picks two-wire or four-wire port
// - status resets to map 0 pattern
`timescale 1ns/1ps
`default_nettype none
module cxp_crosspoint_config_maps #(
  parameter logic [4:0] I2C_BASE = cxp_pkg::CXP_I2C_BASE
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Control port pins
  input wire logic ser_mode_i,
  input wire logic slave_addr_msb_pin_i,
  input wire logic slave_addr_lsb_pin_i,
  input wire logic scl_sck_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  input wire logic crosspoint_update_i,
  // Lanes and per-lane settings
  input wire logic [15:0] lane_i,
  output logic [15:0] lane_o,
  output logic [63:0] crosspoint_state_o,
  output logic [15:0] input_boost_bit_o,
  output logic [15:0] lane_polarity_o
);
  import cxp_pkg::*;

  cxp_pins_type sy1_q, sy2_q, pin_now;
  logic scl3_q, sda3_q, upd3_q;
  logic [63:0] map0_q, map0_d, map1_q, map1_d, act_q, act_d;
  logic sel_q;
  logic [15:0] eq_q, pol_q, out_q, out_d, lane_pol;
  logic [4:0] sp_cnt_q;
  logic [7:0] sp_sh_q, sp_byte, sp_addr_q, rsp_q;
  logic sp_rd_q, sp_tog_q, sp_go, sp_wr_go, sp_rd_go;
  logic sdo_q, sdo_oe_n_q;
  cxp_req_type sp_req_q;
  logic t1_q, t2_q, t3_q, spi_ev, spi_wr, spi_rd;
  cxp_i2c_state_type i_st_q, i_st_d;
  logic [3:0] i_bit_q, i_bit_d;
  logic [7:0] i_sh_q, i_sh_d, ptr_q, ptr_d, i_rb_q, i_rb_d;
  logic drv_q, drv_d, mack_q, mack_d, ird_q, ird_d;
  logic scl_rise, scl_fall, start, stop, match, i2c_wr;
  logic wr_en, wr_upd, wr_sel, wr_bc, wr_m0, wr_m1, upd_fall, upd_go;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, m0_rd, m1_rd, st_rd;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage feeds logic
  assign pin_now = '{ser_mode_i, slave_addr_msb_pin_i,
                     slave_addr_lsb_pin_i, scl_sck_i, sda_i,
                     crosspoint_update_i, lane_i};
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sy1_q <= CXP_PINS_RST;
      sy2_q <= CXP_PINS_RST;
    end else begin
      sy1_q <= pin_now;
      sy2_q <= sy1_q;
    end
  end

  // Edge history; strobe history starts high so reset makes no edge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl3_q <= 1'b1;
      sda3_q <= 1'b1;
      upd3_q <= 1'b1;
    end else begin
      scl3_q <= sy2_q.scl;
      sda3_q <= sy2_q.sda;
      upd3_q <= sy2_q.upd;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Four-wire port, clocked by the serial clock itself. Frame: command
  // byte (bit 0 set = read), address byte, then data in or out.
  // chip select clears the frame
  always_ff @(posedge scl_sck_i or posedge slave_addr_lsb_pin_i
              or posedge sys_rst_i) begin
    if (sys_rst_i || slave_addr_lsb_pin_i) begin
      sp_cnt_q <= 5'd0;
    end else if (sp_cnt_q != CXP_SPI_LAST) begin
      sp_cnt_q <= sp_cnt_q + 5'd1;
    end
  end

  assign sp_byte = {sp_sh_q[6:0], slave_addr_msb_pin_i};
  assign sp_go = ser_mode_i && !slave_addr_lsb_pin_i;
  assign sp_wr_go = sp_go && !sp_rd_q && sp_cnt_q == CXP_SPI_WR_END;
  assign sp_rd_go = sp_go && sp_rd_q && sp_cnt_q == CXP_SPI_ADR_END;

  // Each finished access flips a toggle; its fields then hold still
  always_ff @(posedge scl_sck_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sp_sh_q <= 8'h00;
      sp_rd_q <= 1'b0;
      sp_addr_q <= 8'h00;
      sp_req_q <= '0;
      sp_tog_q <= 1'b0;
    end else begin
      sp_sh_q <= sp_byte;
      if (sp_cnt_q == CXP_SPI_CMD_END) sp_rd_q <= slave_addr_msb_pin_i;
      if (sp_cnt_q == CXP_SPI_ADR_END) sp_addr_q <= sp_byte;
      if (sp_wr_go || sp_rd_go) begin
        sp_req_q <= '{sp_rd_q, sp_rd_go ? sp_byte : sp_addr_q, sp_byte};
        sp_tog_q <= ~sp_tog_q;
      end
    end
  end

  // Read data leaves on the falling edge. The dummy byte gives the
  // system side eight serial clocks to answer, so the serial clock
  // must not be faster than about three system clocks per byte.
  always_ff @(negedge scl_sck_i or posedge slave_addr_lsb_pin_i
              or posedge sys_rst_i) begin
    if (sys_rst_i || slave_addr_lsb_pin_i) begin
      sdo_q <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end else if (ser_mode_i && sp_rd_q && sp_cnt_q >= CXP_SPI_RD_BEG) begin
      sdo_q <= rsp_q[~sp_cnt_q[2:0]];
      sdo_oe_n_q <= 1'b0;
    end
  end

  // Toggle handshake into the system clock
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      t3_q <= 1'b0;
      rsp_q <= 8'h00;
    end else begin
      t1_q <= sp_tog_q;
      t2_q <= t1_q;
      t3_q <= t2_q;
      if (spi_rd) rsp_q <= rd_data;
    end
  end

  assign spi_ev = (t2_q ^ t3_q) && sy2_q.mode;
  assign spi_wr = spi_ev && !sp_req_q.rd;
  assign spi_rd = spi_ev && sp_req_q.rd;

  //////////////////////////////////////////////////////////////////////
  // Two-wire port, oversampled by the system clock
  assign scl_rise = sy2_q.scl && !scl3_q;
  assign scl_fall = !sy2_q.scl && scl3_q;
  assign start = sy2_q.scl && scl3_q && sda3_q && !sy2_q.sda;
  assign stop = sy2_q.scl && scl3_q && !sda3_q && sy2_q.sda;
  // address pins give the two low bits
  assign match = i_sh_q[7:1] == {I2C_BASE, sy2_q.amsb, sy2_q.alsb};
  assign i2c_wr = !sy2_q.mode && scl_fall && i_bit_q == 4'd8
                  && i_st_q == CXP_I_WDATA;

  // Byte engine: first data byte after the address sets the pointer,
  // later bytes go to successive registers
  always_comb begin
    i_st_d = i_st_q;
    i_bit_d = i_bit_q;
    i_sh_d = i_sh_q;
    ptr_d = ptr_q;
    drv_d = drv_q;
    mack_d = mack_q;
    ird_d = ird_q;
    i_rb_d = i_rb_q;
    if (sy2_q.mode) begin
      i_st_d = CXP_I_IDLE;
      drv_d = 1'b0;
    end else if (start) begin
      i_st_d = CXP_I_ADDR;
      i_bit_d = 4'd0;
      drv_d = 1'b0;
    end else if (stop) begin
      i_st_d = CXP_I_IDLE;
      drv_d = 1'b0;
    end else if (i_st_q != CXP_I_IDLE && scl_rise) begin
      if (i_bit_q < 4'd8) begin
        i_sh_d = {i_sh_q[6:0], sy2_q.sda};
        i_bit_d = i_bit_q + 4'd1;
      end else begin
        i_bit_d = 4'd9;
        mack_d = sy2_q.sda;
      end
    end else if (i_st_q != CXP_I_IDLE && scl_fall) begin
      if (i_bit_q == 4'd8) begin
        drv_d = i_st_q != CXP_I_RDATA;
        case (i_st_q)
          CXP_I_ADDR: begin
            ird_d = i_sh_q[0];
            if (!match) begin
              i_st_d = CXP_I_IDLE;
              drv_d = 1'b0;
            end
          end
          CXP_I_REG: ptr_d = i_sh_q;
          CXP_I_RDATA: ptr_d = ptr_q + 8'd1;
          default: ;
        endcase
      end else if (i_bit_q == 4'd9) begin
        i_bit_d = 4'd0;
        drv_d = 1'b0;
        case (i_st_q)
          CXP_I_ADDR: i_st_d = ird_q ? CXP_I_RDATA : CXP_I_REG;
          CXP_I_REG: i_st_d = CXP_I_WDATA;
          CXP_I_WDATA: ptr_d = ptr_q + 8'd1;
          CXP_I_RDATA: if (mack_q) i_st_d = CXP_I_IDLE;
          default: ;
        endcase
        if ((i_st_q == CXP_I_ADDR && ird_q)
            || (i_st_q == CXP_I_RDATA && !mack_q)) begin
          i_rb_d = rd_data;
          drv_d = ~rd_data[7];
        end
      end else if (i_st_q == CXP_I_RDATA) begin
        drv_d = ~i_rb_q[3'd7 - i_bit_q[2:0]];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      i_st_q <= CXP_I_IDLE;
      i_bit_q <= 4'd0;
      i_sh_q <= 8'h00;
      ptr_q <= 8'h00;
      drv_q <= 1'b0;
      mack_q <= 1'b1;
      ird_q <= 1'b0;
      i_rb_q <= 8'h00;
    end else begin
      i_st_q <= i_st_d;
      i_bit_q <= i_bit_d;
      i_sh_q <= i_sh_d;
      ptr_q <= ptr_d;
      drv_q <= drv_d;
      mack_q <= mack_d;
      ird_q <= ird_d;
      i_rb_q <= i_rb_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register decode; the idle port cannot write, so no arbitration
  assign wr_en = i2c_wr || spi_wr;
  assign wr_addr = sy2_q.mode ? sp_req_q.addr : ptr_q;
  assign wr_data = sy2_q.mode ? sp_req_q.data : i_sh_q;
  assign rd_addr = wr_addr;
  // only bit 0 set starts an update
  assign wr_upd = wr_en && wr_addr == CXP_UPD && wr_data[0];
  assign wr_sel = wr_en && wr_addr == CXP_SEL;
  assign wr_bc = wr_en && wr_addr == CXP_BCAST;
  assign wr_m0 = wr_en && wr_addr[7:3] == CXP_MAP0[7:3];
  assign wr_m1 = wr_en && wr_addr[7:3] == CXP_MAP1[7:3];
  assign upd_fall = !sy2_q.upd && upd3_q;
  assign upd_go = wr_upd || upd_fall;

  // one byte carries two output fields
  // broadcast wins over a map byte write
  always_comb begin
    map0_d = map0_q;
    map1_d = map1_q;
    if (wr_m0) map0_d[{wr_addr[2:0], 3'b000} +: 8] = wr_data;
    if (wr_m1) map1_d[{wr_addr[2:0], 3'b000} +: 8] = wr_data;
    if (wr_bc && !sel_q) map0_d = {16{wr_data[3:0]}};
    if (wr_bc && sel_q) map1_d = {16{wr_data[3:0]}};
  end

  // second rank loads only from the selected first rank
  // nothing else moves the active rank
  assign act_d = upd_go ? (sel_q ? map1_q : map0_q) : act_q;

  // Register file
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      map0_q <= CXP_MAP0_RST;
      map1_q <= CXP_MAP1_RST;
      // active rank starts as map 0
      act_q <= CXP_MAP0_RST;
      sel_q <= 1'b0;
      eq_q <= CXP_EQ_RST;
      pol_q <= CXP_POL_RST;
    end else begin
      map0_q <= map0_d;
      map1_q <= map1_d;
      act_q <= act_d;
      if (wr_sel) sel_q <= wr_data[0];
      if (wr_en && wr_addr == CXP_EQ_LO) eq_q[7:0] <= wr_data;
      if (wr_en && wr_addr == CXP_EQ_HI) eq_q[15:8] <= wr_data;
      if (wr_en && wr_addr == CXP_POL_LO) pol_q[7:0] <= wr_data;
      if (wr_en && wr_addr == CXP_POL_HI) pol_q[15:8] <= wr_data;
    end
  end

  // Read mux; update and broadcast hold nothing and read zero
  assign m0_rd = map0_q[{rd_addr[2:0], 3'b000} +: 8];
  assign m1_rd = map1_q[{rd_addr[2:0], 3'b000} +: 8];
  assign st_rd = act_q[{rd_addr[2:0], 3'b000} +: 8];
  assign rd_data =
    (rd_addr == CXP_EQ_LO) ? eq_q[7:0] :
    (rd_addr == CXP_EQ_HI) ? eq_q[15:8] :
    (rd_addr == CXP_POL_LO) ? pol_q[7:0] :
    (rd_addr == CXP_POL_HI) ? pol_q[15:8] :
    (rd_addr == CXP_SEL) ? {7'h00, sel_q} :
    (rd_addr[7:3] == CXP_MAP0[7:3]) ? m0_rd :
    (rd_addr[7:3] == CXP_MAP1[7:3]) ? m1_rd :
    (rd_addr[7:3] == CXP_STAT[7:3]) ? st_rd : 8'h00;

  //////////////////////////////////////////////////////////////////////
  // Switch core: polarity belongs to the input, so it is applied
  // before selection and follows the lane to every output it feeds
  assign lane_pol = sy2_q.lane ^ pol_q;
  // field value is the input number
  always_comb begin
    out_d = 16'h0000;
    for (int n = 0; n < 16; n++) begin
      out_d[n] = lane_pol[act_q[4*n +: 4]];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) out_q <= 16'h0000;
    else out_q <= out_d;
  end

  assign lane_o = out_q;
  assign crosspoint_state_o = act_q;
  assign input_boost_bit_o = eq_q;
  assign lane_polarity_o = pol_q;
  assign sda_o = 1'b0;      // Open drain: only ever pulls low
  assign sda_oe_n_o = ~drv_q;
  assign sdo_o = sdo_q;
  assign sdo_oe_n_o = sdo_oe_n_q;

  //////////////////////////////////////////////////////////////////////
  // Checks on the system clock
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_reset_maps: assert property (
    $fell(sys_rst_i) |-> map0_q == CXP_MAP0_RST
      && map1_q == CXP_MAP1_RST && act_q == CXP_MAP0_RST)
    else $error("maps not at reset pattern");
  a_sel_write: assert property (
    wr_sel |=> sel_q == $past(wr_data[0]))
    else $error("map select not taken");
  a_reg_update: assert property (
    wr_upd |=> act_q == $past(sel_q ? map1_q : map0_q))
    else $error("update write did not copy map");
  a_pin_update: assert property (
    $fell(sy2_q.upd) |-> ##1 act_q == $past(sel_q ? map1_q : map0_q))
    else $error("strobe edge did not copy map");
  a_rank_hold: assert property (
    !wr_upd && !upd_fall |=> $stable(act_q))
    else $error("active rank moved without update");
  a_bcast_fill: assert property (
    wr_bc |=> ($past(sel_q) ? map1_q : map0_q) ==
      {16{$past(wr_data[3:0])}}
      && ($past(sel_q) ? $stable(map0_q) : $stable(map1_q)))
    else $error("broadcast did not fill selected map");
  a_status_read: assert property (
    rd_addr[7:3] == CXP_STAT[7:3] |->
      rd_data[3:0] == act_q[{rd_addr[2:0], 1'b0, 2'b00} +: 4]
      && rd_data[7:4] == act_q[{rd_addr[2:0], 1'b1, 2'b00} +: 4])
    else $error("status read wrong");
  a_upd_reads_zero: assert property (
    rd_addr == CXP_UPD || rd_addr == CXP_BCAST |-> rd_data == 8'h00)
    else $error("write-only register read nonzero");
  a_route_lane0: assert property (
    $stable(act_q) && $stable(pol_q) |=> lane_o[0] ==
      $past(sy2_q.lane[act_q[3:0]] ^ pol_q[act_q[3:0]]))
    else $error("output 0 not routed from its input");

  c_reg_update: cover property (wr_upd && sel_q);
  c_pin_update: cover property (upd_fall);
  c_i2c_write: cover property (i2c_wr && wr_addr[7:3] == CXP_MAP1[7:3]);
  c_spi_read: cover property (spi_rd);
endmodule
`default_nettype wire

// ---- testbench/cxp_spi_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module cxp_spi_host (
  // Serial control pins toward the device
  output logic sck_o,
  output logic sdi_o,
  output logic cs_n_o,
  // Host side of the open-drain data wire, high means released
  output logic sda_drv_o,
  // Shared data pin as resolved on the board
  input wire logic sdo_i
);
  // Clock stands low and select stays high between frames
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    cs_n_o = 1'b1;
    sda_drv_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // One frame: command, address, data or dummy, then the read byte
  // one register byte per frame
  task automatic xfer(input logic rd, input logic [7:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [31:0] frame;
    int nbits;
    begin
      frame = {7'h00, rd, addr, wdata, 8'h00};
      nbits = rd ? 32 : 24;
      rdata = 8'h00;
      cs_n_o = 1'b0;
      for (int i = 0; i < nbits; i++) begin
        sdi_o = frame[31-i];
        #15 sck_o = 1'b1;
        if (i >= 24) rdata = {rdata[6:0], sdo_i};
        #15 sck_o = 1'b0;
      end
      #15 cs_n_o = 1'b1;
      // Released line shows the inverse so a stale bit cannot pass
      sdi_o = ~sdi_o;
      #30;
    end
  endtask

  // Two-wire write of three bytes, clock high and low 300 ns each.
  // Address pins stay put: select line high, data-in line low.
  // two-wire frame with start, acks and stop
  task automatic i2c_wr3(input logic [23:0] bytes,
                         output logic [2:0] acks);
    begin
      sdi_o = 1'b0;
      cs_n_o = 1'b1;
      sck_o = 1'b1;
      sda_drv_o = 1'b1;
      #300 sda_drv_o = 1'b0;
      #300;
      for (int j = 0; j < 3; j++) begin
        for (int i = 0; i < 9; i++) begin
          sck_o = 1'b0;
          #150 sda_drv_o = (i == 8) ? 1'b1 : bytes[23 - 8 * j - i];
          #150 sck_o = 1'b1;
          #150 if (i == 8) acks[2 - j] = sdo_i;
          #150;
        end
      end
      sck_o = 1'b0;
      #150 sda_drv_o = 1'b0;
      #150 sck_o = 1'b1;
      #150 sda_drv_o = 1'b1;
      #300;
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench/cxp_crosspoint_config_maps_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cxp_crosspoint_config_maps_tb;
  import cxp_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ser_mode_i = 1'b1;
  logic crosspoint_update_i = 1'b1;
  logic [15:0] lane_i = 16'h0000;
  logic sck, sdi, cs_n, sda_o, sda_oe_n_o, sdo_o, sdo_oe_n_o, pin_line;
  logic host_sda;
  logic [15:0] lane_o, input_boost_bit_o, lane_polarity_o;
  logic [63:0] crosspoint_state_o;
  int mismatches = 0;
  int compares = 0;

  // 20 MHz system clock
  always #25 clk_i = ~clk_i;

  // Shared pin: wired-and of both open drains and SDO, else pull-up
  assign pin_line = host_sda & (sda_oe_n_o | sda_o)
                    & (sdo_oe_n_o | sdo_o);

  ////////////////////////////////////////////////////////////////////////
  // Host model and device
  cxp_spi_host u_host (.sck_o(sck), .sdi_o(sdi), .cs_n_o(cs_n),
                       .sda_drv_o(host_sda), .sdo_i(pin_line));
  cxp_crosspoint_config_maps u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ser_mode_i(ser_mode_i),
    .slave_addr_msb_pin_i(sdi), .slave_addr_lsb_pin_i(cs_n),
    .scl_sck_i(sck), .sda_i(pin_line), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
    .crosspoint_update_i(crosspoint_update_i), .lane_i(lane_i),
    .lane_o(lane_o), .crosspoint_state_o(crosspoint_state_o),
    .input_boost_bit_o(input_boost_bit_o),
    .lane_polarity_o(lane_polarity_o));

  ////////////////////////////////////////////////////////////////////////
  // Compare tasks, one per result width
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk16(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk64(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register access; no handshake, so wait past the sync delay
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] junk;
    begin
      u_host.xfer(1'b0, a, d, junk);
      repeat (8) @(posedge clk_i);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    u_host.xfer(1'b1, a, 8'h00, d);
  endtask

  // Strobe pin level change, then let the synchroniser settle
  task automatic strobe(input logic lvl);
    @(negedge clk_i) crosspoint_update_i = lvl;
    repeat (6) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset values of every map byte, status, select and the lanes
  task automatic t_reset;
    logic [7:0] v;
    begin
      chk64("state", CXP_MAP0_RST, crosspoint_state_o);
      chk16("boost", 16'hffff, input_boost_bit_o);
      chk16("polarity", 16'h0000, lane_polarity_o);
      for (int k = 0; k < 8; k++) begin
        rd(CXP_MAP0 + 8'(k), v);
        chk8("map0", {4'(14 - 2 * k), 4'(15 - 2 * k)}, v);
        rd(CXP_MAP1 + 8'(k), v);
        chk8("map1", {4'(2 * k + 1), 4'(2 * k)}, v);
        rd(CXP_STAT + 8'(k), v);
        chk8("status", {4'(14 - 2 * k), 4'(15 - 2 * k)}, v);
      end
      rd(CXP_SEL, v);
      chk8("select", 8'h00, v);
      // Reversed diagonal: lane n appears on output 15 minus n
      @(negedge clk_i) lane_i = 16'h1234;
      repeat (6) @(posedge clk_i);
      chk16("lanes", 16'h2c48, lane_o);
      $display("t_reset done");
    end
  endtask

  // Map write stays pending until a real update request
  task automatic t_update;
    logic [7:0] v;
    begin
      wr(CXP_MAP0, 8'h5a);
      rd(CXP_MAP0, v);
      chk8("map0 byte", 8'h5a, v);
      chk64("state", CXP_MAP0_RST, crosspoint_state_o);
      wr(CXP_UPD, 8'h00);
      chk64("state", CXP_MAP0_RST, crosspoint_state_o);
      wr(CXP_UPD, 8'h01);
      chk64("state", {CXP_MAP0_RST[63:8], 8'h5a}, crosspoint_state_o);
      rd(CXP_UPD, v);
      chk8("update read", 8'h00, v);
      rd(CXP_STAT, v);
      chk8("status", 8'h5a, v);
      $display("t_update done");
    end
  endtask

  // Broadcast into map 1 and update by strobe edges only
  task automatic t_bcast;
    logic [7:0] v;
    begin
      wr(CXP_SEL, 8'h01);
      rd(CXP_SEL, v);
      chk8("select", 8'h01, v);
      chk64("state", {CXP_MAP0_RST[63:8], 8'h5a}, crosspoint_state_o);
      wr(CXP_BCAST, 8'h07);
      rd(CXP_MAP1 + 8'h07, v);
      chk8("map1 byte", 8'h77, v);
      rd(CXP_MAP0, v);
      chk8("map0 byte", 8'h5a, v);
      strobe(1'b0);
      chk64("state", {16{4'h7}}, crosspoint_state_o);
      wr(CXP_BCAST, 8'h03);
      strobe(1'b1);
      chk64("state", {16{4'h7}}, crosspoint_state_o);
      strobe(1'b0);
      chk64("state", {16{4'h3}}, crosspoint_state_o);
      strobe(1'b1);
      $display("t_bcast done");
    end
  endtask

  // Multicast of one lane, per-input polarity and boost bits
  task automatic t_lanes;
    begin
      @(negedge clk_i) lane_i = 16'h0008;
      repeat (6) @(posedge clk_i);
      chk16("lanes", 16'hffff, lane_o);
      @(negedge clk_i) lane_i = 16'hfff7;
      repeat (6) @(posedge clk_i);
      chk16("lanes", 16'h0000, lane_o);
      wr(CXP_POL_LO, 8'h08);
      chk16("polarity", 16'h0008, lane_polarity_o);
      chk16("lanes", 16'hffff, lane_o);
      wr(CXP_EQ_HI, 8'h00);
      chk16("boost", 16'h00ff, input_boost_bit_o);
      $display("t_lanes done");
    end
  endtask

  // Two-wire port: matching address is acked and writes, other is not
  task automatic t_i2c;
    logic [2:0] acks;
    begin
      @(negedge clk_i) ser_mode_i = 1'b0;
      repeat (4) @(posedge clk_i);
      u_host.i2c_wr3({8'h92, CXP_POL_HI, 8'h80}, acks);
      chk8("i2c acks", 8'h00, {5'h00, acks});
      chk16("polarity", 16'h8008, lane_polarity_o);
      u_host.i2c_wr3({8'h96, CXP_POL_HI, 8'h00}, acks);
      chk8("i2c nacks", 8'h07, {5'h00, acks});
      chk16("polarity", 16'h8008, lane_polarity_o);
      $display("t_i2c done");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic summarize;
    $display("Checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i) sys_rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset;
    t_update;
    t_bcast;
    t_lanes;
    t_i2c;
    summarize;
  end

  // Watchdog, well beyond the roughly 1600 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    summarize;
  end
endmodule
`default_nettype wire
